// file: logic/hcu_ctrl.sv
// Channel control block: control register, transmit line sequencer,
// test-mode routing, modem lines and DMA descriptor decisions.
// Assumes an APB master on pclk and an external framer and receiver.
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module hcu_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  input wire logic clear_to_send_n,
  input wire logic carrier_detect_n,
  output logic txd,
  output logic terminal_ready_n,
  input wire logic tx_data_avail,
  input wire logic tx_frame_bit,
  input wire logic tx_frame_done,
  output logic tx_frame_go,
  output logic tx_bit_tick,
  output logic rx_serial,
  input wire logic [7:0] rx_byte,
  input wire logic rx_byte_valid,
  input wire logic rx_frame_start,
  input wire logic rx_frame_end,
  output logic [31:0] rx_word,
  output logic rx_word_valid,
  output logic frame_drop,
  output logic tx_crc_append,
  output logic rx_crc_check,
  output logic tx_fifo_clear,
  output logic rx_fifo_clear,
  output logic rx_halt,
  input wire logic tx_desc_check,
  input wire logic tx_desc_owned,
  input wire logic rx_desc_check,
  input wire logic rx_desc_owned,
  output logic tx_dma_stop,
  output logic tx_desc_skip,
  output logic rx_dma_stop,
  output logic rx_desc_skip,
  input wire logic [31:0] rx_dma_base,
  input wire logic rx_dma_load,
  input wire logic rx_dma_step,
  output logic [31:0] rx_dma_addr
);
  import hcu_pkg::*;

  logic [31:0] ctrl; // Channel control register.
  logic [15:0] prmb; // Preamble pattern [7:0] and repeat count [15:8].
  logic [2:0] sync1; // First synchroniser stage, read only by sync2.
  logic [2:0] sync2; // Synchronised rxd, clear-to-send, carrier-detect.
  logic [3:0] div_cnt; // Bit-rate divider.
  hcu_state_t state; // Transmit sequencer state.
  logic [7:0] sh; // Pattern shift register, sent LSB first.
  logic [2:0] bc; // Bit count inside the current pattern byte.
  logic [7:0] left; // Preamble or abort bytes still to send.
  logic mark_force; // Mark idle forced after an extended abort.
  logic txd_bit; // Serial bit as produced by the sequencer.
  logic wr_en; // APB write completes this cycle.
  logic cts_hi; // Send-clear inactive and honoured.
  logic dcd_hi; // Carrier-detect inactive and honoured.
  logic abt_go; // Abort is being initiated this cycle.
  logic [7:0] idle_pat; // Pattern sent while idle.

  // Register hit test, shared by the read and write paths.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // The write lands at the edge where the master sees pready.
  assign wr_en = psel && penable && pready && pwrite;

  // APB answer: one wait state, so read data can come from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        pslverr <= !(hit(paddr, HCU_OFS_CTRL) || hit(paddr, HCU_OFS_PRMB) ||
                     hit(paddr, HCU_OFS_STAT));
        if (hit(paddr, HCU_OFS_CTRL)) begin
          prdata <= ctrl & HCU_CTRL_WMASK;
        end else if (hit(paddr, HCU_OFS_PRMB)) begin
          prdata <= {16'h0000, prmb};
        end else if (hit(paddr, HCU_OFS_STAT)) begin
          prdata <= {22'h00_0000, rx_halt, dcd_hi, cts_hi, mark_force, state};
        end else begin
          // Unmapped offsets read zero and flag an error.
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

  // Two-flop synchroniser for the three line inputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 3'h7;
      sync2 <= 3'h7;
    end else begin
      sync1 <= {carrier_detect_n, clear_to_send_n, rxd};
      sync2 <= sync1;
    end
  end

  assign cts_hi = sync2[1] && !ctrl[HCU_B_LOOP] &&
                  ctrl[HCU_B_TRANSMITTER_ENABLE] && ctrl[HCU_B_RECEIVER_ENABLE];
  assign dcd_hi = sync2[2] && !ctrl[HCU_B_LOOP] &&
                  ctrl[HCU_B_TRANSMITTER_ENABLE] && ctrl[HCU_B_RECEIVER_ENABLE];
  // Abort starts when requested, unless auto mode is resetting the block.
  assign abt_go = ctrl[HCU_B_ABT] && !(cts_hi && ctrl[HCU_B_AUTO]);

  // Control register; software writes override hardware clears.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= HCU_CTRL_RST;
      prmb <= HCU_PRMB_RST;
    end else begin
      if (abt_go) begin
        ctrl[HCU_B_ABT] <= 1'b0;
      end
      ctrl[HCU_B_DISC] <= 1'b0;
      if (tx_desc_check && !tx_desc_owned && ctrl[HCU_B_TXSTSK]) begin
        ctrl[HCU_B_DTXEN] <= 1'b0;
      end
      if (rx_desc_check && !rx_desc_owned && ctrl[HCU_B_RXSTSK]) begin
        ctrl[HCU_B_DRXEN] <= 1'b0;
      end
      if (wr_en && hit(paddr, HCU_OFS_CTRL)) begin
        ctrl <= pwdata & HCU_CTRL_WMASK;
      end
      if (wr_en && hit(paddr, HCU_OFS_PRMB)) begin
        prmb <= pwdata[15:0];
      end
    end
  end

  // Bit-rate divider; one enable pulse per serial bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 4'h0;
      tx_bit_tick <= 1'b0;
    end else begin
      div_cnt <= (div_cnt == HCU_BIT_DIV) ? 4'h0 : div_cnt + 4'h1;
      tx_bit_tick <= (div_cnt == HCU_BIT_DIV);
    end
  end

  assign idle_pat = (ctrl[HCU_B_IDLE] && !mark_force && !cts_hi) ?
                    HCU_FLAG : HCU_MARK;

  // Transmit sequencer. Patterns go out a byte at a time on ticks; frame
  // bits come from the framer while in the data state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= HCU_ST_IDLE;
      sh <= HCU_MARK;
      bc <= 3'h0;
      left <= 8'h00;
      mark_force <= 1'b0;
      txd_bit <= 1'b1;
    end else if (cts_hi && ctrl[HCU_B_AUTO]) begin
      state <= HCU_ST_IDLE;
      sh <= HCU_MARK;
      bc <= 3'h0;
      txd_bit <= 1'b1;
    end else if (abt_go) begin
      state <= HCU_ST_ABORT;
      sh <= HCU_MARK;
      bc <= 3'h0;
      left <= {6'h00, ctrl[HCU_B_ABTEXT] ? HCU_ABTX_BYTES : HCU_ABT_BYTES};
      mark_force <= ctrl[HCU_B_ABTEXT];
    end else if (tx_bit_tick) begin
      if (state == HCU_ST_DATA) begin
        txd_bit <= tx_frame_bit;
        if (tx_frame_done) begin
          state <= HCU_ST_CLOSE;
          sh <= HCU_FLAG;
          bc <= 3'h0;
        end
      end else begin
        txd_bit <= sh[0];
        sh <= {1'b1, sh[7:1]};
        bc <= bc + 3'h1;
        if (bc == 3'h7) begin
          case (state)
            HCU_ST_IDLE: begin
              if (tx_data_avail && !cts_hi) begin
                mark_force <= 1'b0;
                if (ctrl[HCU_B_PRMB] && !ctrl[HCU_B_DTXEN] &&
                    prmb[15:8] != 8'h00) begin
                  state <= HCU_ST_PRE;
                  sh <= prmb[7:0];
                  left <= prmb[15:8];
                end else begin
                  state <= HCU_ST_OPEN;
                  sh <= HCU_FLAG;
                end
              end else begin
                sh <= idle_pat;
              end
            end
            HCU_ST_PRE: begin
              left <= left - 8'h01;
              if (left == 8'h01) begin
                state <= HCU_ST_OPEN;
                sh <= HCU_FLAG;
              end else begin
                sh <= prmb[7:0];
              end
            end
            HCU_ST_OPEN: begin
              state <= HCU_ST_DATA;
            end
            HCU_ST_CLOSE: begin
              if (tx_data_avail && !cts_hi && ctrl[HCU_B_SFLAG]) begin
                state <= HCU_ST_DATA;
              end else if (tx_data_avail && !cts_hi) begin
                state <= HCU_ST_OPEN;
                sh <= HCU_FLAG;
              end else begin
                state <= HCU_ST_IDLE;
                sh <= idle_pat;
              end
            end
            HCU_ST_ABORT: begin
              left <= left - 8'h01;
              if (left == 8'h01) begin
                state <= HCU_ST_IDLE;
                sh <= idle_pat;
              end else begin
                sh <= HCU_MARK;
              end
            end
            default: begin
              state <= HCU_ST_IDLE;
              sh <= HCU_MARK;
            end
          endcase
        end
      end
    end
  end

  // Pin and test-mode routing, plus static control outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd <= 1'b1;
      rx_serial <= 1'b1;
      terminal_ready_n <= 1'b1;
      tx_frame_go <= 1'b0;
      frame_drop <= 1'b0;
      tx_crc_append <= 1'b1;
      rx_crc_check <= 1'b1;
      tx_fifo_clear <= 1'b0;
      rx_fifo_clear <= 1'b0;
      rx_halt <= 1'b0;
    end else begin
      txd <= ctrl[HCU_B_ECHO] ? sync2[0] : txd_bit;
      rx_serial <= ctrl[HCU_B_LOOP] ? txd_bit : sync2[0];
      terminal_ready_n <= !ctrl[HCU_B_DTR];
      tx_frame_go <= (state == HCU_ST_DATA);
      frame_drop <= ctrl[HCU_B_DISC];
      tx_crc_append <= !ctrl[HCU_B_TX_CRC_SUPPRESS];
      rx_crc_check <= !ctrl[HCU_B_RX_CRC_SUPPRESS];
      tx_fifo_clear <= abt_go || (cts_hi && ctrl[HCU_B_AUTO]);
      rx_fifo_clear <= dcd_hi && ctrl[HCU_B_AUTO];
      rx_halt <= dcd_hi && ctrl[HCU_B_AUTO];
    end
  end

  // Descriptor ownership decisions and receive address stepping.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_dma_stop <= 1'b0;
      tx_desc_skip <= 1'b0;
      rx_dma_stop <= 1'b0;
      rx_desc_skip <= 1'b0;
      rx_dma_addr <= 32'h0000_0000;
    end else begin
      tx_dma_stop <= tx_desc_check && !tx_desc_owned && ctrl[HCU_B_TXSTSK];
      tx_desc_skip <= tx_desc_check && !tx_desc_owned && !ctrl[HCU_B_TXSTSK];
      rx_dma_stop <= rx_desc_check && !rx_desc_owned && ctrl[HCU_B_RXSTSK];
      rx_desc_skip <= rx_desc_check && !rx_desc_owned && !ctrl[HCU_B_RXSTSK];
      if (rx_dma_load) begin
        rx_dma_addr <= rx_dma_base;
      end else if (rx_dma_step) begin
        rx_dma_addr <= ctrl[HCU_B_ADEC] ? rx_dma_addr - HCU_ADDR_STEP :
                       rx_dma_addr + HCU_ADDR_STEP;
      end
    end
  end

  // Receive word assembly with first-word padding and frame discard.
  hcu_rx_packer u_packer (
    .clk(pclk),
    .rst_n(presetn),
    .pad(ctrl[HCU_B_ALIGN +: 2]),
    .byte_in(rx_byte),
    .byte_valid(rx_byte_valid),
    .frame_start(rx_frame_start),
    .frame_end(rx_frame_end),
    .drop(frame_drop),
    .halt(rx_halt),
    .word(rx_word),
    .word_valid(rx_word_valid)
  );

  // Helper count of ones sent during an abort, for checking only.
  logic [4:0] abt_ones;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abt_ones <= 5'h00;
    end else if (abt_go) begin
      abt_ones <= 5'h00;
    end else if (tx_bit_tick && state == HCU_ST_ABORT && abt_ones != 5'h1F) begin
      abt_ones <= abt_ones + 5'h01;
    end
  end

  sequence s_abt_start;
    abt_go && !(wr_en && hit(paddr, HCU_OFS_CTRL));
  endsequence

  property p_abt_clear;
    @(posedge pclk) disable iff (!presetn)
    s_abt_start |=> !ctrl[HCU_B_ABT] && state == HCU_ST_ABORT && tx_fifo_clear;
  endproperty
  a_abt_clear: assert property (p_abt_clear) else $error("abort not started");

  property p_abt_len;
    @(posedge pclk) disable iff (!presetn)
    $fell(state == HCU_ST_ABORT) && !abt_go &&
      !$past(cts_hi && ctrl[HCU_B_AUTO])
      |-> abt_ones >= (mark_force ? 5'h10 : 5'h08);
  endproperty
  a_abt_len: assert property (p_abt_len) else $error("abort too short");

  property p_disc;
    @(posedge pclk) disable iff (!presetn)
    ctrl[HCU_B_DISC] && !wr_en |=> !ctrl[HCU_B_DISC] ##0 frame_drop;
  endproperty
  a_disc: assert property (p_disc) else $error("discard not one cycle");

  property p_dtr;
    @(posedge pclk) disable iff (!presetn)
    ##1 terminal_ready_n == !$past(ctrl[HCU_B_DTR]);
  endproperty
  a_dtr: assert property (p_dtr) else $error("ready pin wrong");

  property p_echo;
    @(posedge pclk) disable iff (!presetn)
    ctrl[HCU_B_ECHO] |=> txd == $past(sync2[0]);
  endproperty
  a_echo: assert property (p_echo) else $error("echo path wrong");

  property p_loop;
    @(posedge pclk) disable iff (!presetn)
    ctrl[HCU_B_LOOP] |=> rx_serial == $past(txd_bit) ##0 !rx_halt;
  endproperty
  a_loop: assert property (p_loop) else $error("loop path wrong");

  property p_crc;
    @(posedge pclk) disable iff (!presetn)
    ##1 tx_crc_append != $past(ctrl[HCU_B_TX_CRC_SUPPRESS]) &&
        rx_crc_check != $past(ctrl[HCU_B_RX_CRC_SUPPRESS]);
  endproperty
  a_crc: assert property (p_crc) else $error("check enables wrong");

  property p_tx_stop;
    @(posedge pclk) disable iff (!presetn)
    tx_desc_check && !tx_desc_owned && ctrl[HCU_B_TXSTSK] && !wr_en
      |=> tx_dma_stop && !tx_desc_skip && !ctrl[HCU_B_DTXEN];
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("tx stop missed");

  property p_auto_cts;
    @(posedge pclk) disable iff (!presetn)
    cts_hi && ctrl[HCU_B_AUTO] |=> state == HCU_ST_IDLE && tx_fifo_clear;
  endproperty
  a_auto_cts: assert property (p_auto_cts) else $error("auto reset missed");

endmodule // hcu_ctrl
`default_nettype wire

// file: logic/hcu_pkg.sv
// Constants shared by the channel control block and its receive packer.
// Assumes a single 200 MHz clock and a 32-bit APB register port.
package hcu_pkg;

  // Register byte offsets on the APB port.
  localparam logic [7:0] HCU_OFS_CTRL = 8'h00;
  localparam logic [7:0] HCU_OFS_PRMB = 8'h04;
  localparam logic [7:0] HCU_OFS_STAT = 8'h08;

  // Control register field positions.
  localparam int HCU_B_TRANSMITTER_ENABLE = 4;
  localparam int HCU_B_RECEIVER_ENABLE = 5;
  localparam int HCU_B_DTXEN = 6;
  localparam int HCU_B_DRXEN = 7;
  localparam int HCU_B_ALIGN = 12;
  localparam int HCU_B_TXSTSK = 14;
  localparam int HCU_B_RXSTSK = 15;
  localparam int HCU_B_ADEC = 16;
  localparam int HCU_B_IDLE = 17;
  localparam int HCU_B_SFLAG = 18;
  localparam int HCU_B_LOOP = 19;
  localparam int HCU_B_ECHO = 20;
  localparam int HCU_B_ABTEXT = 21;
  localparam int HCU_B_ABT = 22;
  localparam int HCU_B_PRMB = 23;
  localparam int HCU_B_DTR = 24;
  localparam int HCU_B_DISC = 25;
  localparam int HCU_B_TX_CRC_SUPPRESS = 26;
  localparam int HCU_B_RX_CRC_SUPPRESS = 27;
  localparam int HCU_B_AUTO = 28;

  // Reset values and the writable mask; the top three bits are reserved.
  localparam logic [31:0] HCU_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] HCU_CTRL_WMASK = 32'h1FFF_FFFF;
  localparam logic [15:0] HCU_PRMB_RST = 16'h0000;

  // Line patterns.
  localparam logic [7:0] HCU_FLAG = 8'h7E;
  localparam logic [7:0] HCU_MARK = 8'hFF;

  // Abort length in bytes of ones, plain and extended.
  localparam logic [1:0] HCU_ABT_BYTES = 2'h1;
  localparam logic [1:0] HCU_ABTX_BYTES = 2'h2;

  // Last divider count (sixteen clock cycles per serial bit), and the receive DMA address step.
  localparam logic [3:0] HCU_BIT_DIV = 4'hF;
  localparam logic [31:0] HCU_ADDR_STEP = 32'h0000_0004;

  // Transmit sequencer states, one-hot.
  typedef enum logic [5:0] {
    HCU_ST_IDLE = 6'b000001,
    HCU_ST_PRE = 6'b000010,
    HCU_ST_OPEN = 6'b000100,
    HCU_ST_DATA = 6'b001000,
    HCU_ST_CLOSE = 6'b010000,
    HCU_ST_ABORT = 6'b100000
  } hcu_state_t;

endpackage

// file: logic/hcu_rx_packer.sv
// Receive word packer: gathers received bytes into 32-bit words.
// Assumes byte strobes from the receiver on the same clock.
`timescale 1ns/100ps
`default_nettype none
module hcu_rx_packer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] pad,
  input wire logic [7:0] byte_in,
  input wire logic byte_valid,
  input wire logic frame_start,
  input wire logic frame_end,
  input wire logic drop,
  input wire logic halt,
  output logic [31:0] word,
  output logic word_valid
);
  import hcu_pkg::*;

  logic [1:0] idx; // Next byte lane, lane 0 is the top byte.
  logic [31:0] acc; // Partly built word.
  logic dropping; // Current frame is being thrown away.
  logic [31:0] next_acc; // Word with the incoming byte merged.

  // First byte lands in the lane set by the pad, lane 0 being the most significant.
  always_comb begin
    next_acc = acc | ({24'h00_0000, byte_in} << {3'h3 - {1'b0, idx}, 3'h0});
  end

  // Frame start restarts the word; pad lanes stay zero as invalid bytes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx <= 2'h0;
      acc <= 32'h0000_0000;
      dropping <= 1'b0;
      word <= 32'h0000_0000;
      word_valid <= 1'b0;
    end else begin
      word_valid <= 1'b0;
      if (halt) begin
        // A halted receiver loses its partial word.
        idx <= 2'h0;
        acc <= 32'h0000_0000;
        dropping <= 1'b0;
      end else if (frame_start) begin
        idx <= pad;
        acc <= 32'h0000_0000;
        dropping <= 1'b0;
      end else if (drop) begin
        dropping <= 1'b1;
        acc <= 32'h0000_0000;
      end else if (byte_valid && !dropping) begin
        if (idx == 2'h3 || frame_end) begin
          word <= next_acc;
          word_valid <= 1'b1;
          acc <= 32'h0000_0000;
          idx <= 2'h0;
        end else begin
          acc <= next_acc;
          idx <= idx + 2'h1;
        end
      end
    end
  end

endmodule // hcu_rx_packer
`default_nettype wire

// file: testbench/hcu_line_model.sv
// Remote station model: flag fill on the receive line, modem pins.
// Assumes the bench clock and reset; the bench commands the pins.
`timescale 1ns/100ps
`default_nettype none
module hcu_line_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cts_off,
  input wire logic dcd_off,
  output logic rxd,
  output logic clear_to_send_n,
  output logic carrier_detect_n
);
  localparam logic [7:0] FILL = 8'h7E; // Flag sent between frames.
  logic [6:0] ph; // Low four bits count cycles, top three the bit index.
  // The remote keeps the line busy with flags, sixteen cycles a bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 7'h00;
      rxd <= 1'b1;
    end else begin
      ph <= ph + 7'h01;
      rxd <= FILL[ph[6:4]];
    end
  end
  // The pins go high when the bench marks a line inactive.
  assign clear_to_send_n = cts_off;
  assign carrier_detect_n = dcd_off;
endmodule // hcu_line_model
`default_nettype wire

// file: testbench/test_hcu_ctrl.sv
// Self-checking bench for the channel control block.
// Assumes the package, the design and the line model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_hcu_ctrl;
  import hcu_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, txd, rxd;
  logic [7:0] paddr, rx_byte, hist;
  logic [31:0] pwdata, prdata, rx_word, rx_dma_base, rx_dma_addr, seed;
  logic clear_to_send_n, carrier_detect_n, terminal_ready_n, tx_frame_go;
  logic tx_bit_tick, rx_serial, rx_byte_valid, rx_frame_start, rx_frame_end;
  logic rx_word_valid, frame_drop, tx_crc_append, rx_crc_check, rx_halt;
  logic tx_fifo_clear, rx_fifo_clear, tx_desc_check, tx_desc_owned;
  logic rx_desc_check, rx_desc_owned, tx_dma_stop, tx_desc_skip, rx_dma_stop;
  logic rx_desc_skip, rx_dma_load, rx_dma_step, cts_off, dcd_off;
  logic seen_clr, seen_drop; // Sticky marks of one-cycle pulses.
  logic tx_avail; // Frame offered to the transmit sequencer.
  logic [2:0] rxh; // Last three sampled receive line bits.
  logic [63:0] rq[$], wq[$]; // Expected {mask, value} for reads, words.
  int fail_count, compares;
  // Frame bits are tied low; only frame availability is driven.
  hcu_ctrl i_hcu_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rxd, .clear_to_send_n,
    .carrier_detect_n, .txd, .terminal_ready_n, .tx_data_avail(tx_avail),
    .tx_frame_bit(1'b0), .tx_frame_done(1'b0), .tx_frame_go, .tx_bit_tick,
    .rx_serial, .rx_byte, .rx_byte_valid, .rx_frame_start, .rx_frame_end,
    .rx_word, .rx_word_valid, .frame_drop, .tx_crc_append, .rx_crc_check,
    .tx_fifo_clear, .rx_fifo_clear, .rx_halt, .tx_desc_check,
    .tx_desc_owned, .rx_desc_check, .rx_desc_owned, .tx_dma_stop,
    .tx_desc_skip, .rx_dma_stop, .rx_desc_skip, .rx_dma_base, .rx_dma_load,
    .rx_dma_step, .rx_dma_addr);
  hcu_line_model i_hcu_line_model (.pclk, .presetn, .cts_off, .dcd_off,
    .rxd, .clear_to_send_n, .carrier_detect_n);
  // Free-running 200 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string w);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, w, got, exp);
    end
  endtask
  task automatic pop(ref logic [63:0] q[$], input logic [31:0] got,
                     input string w);
    logic [63:0] e;
    if (q.size() == 0) begin
      check(32'h1, 32'h0, w);
    end else begin
      e = q.pop_front();
      check(got & e[63:32], e[31:0], w);
    end
  endtask
  task automatic tally_and_finish();
    $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One APB transfer; reads leave their expected value for the watcher.
  task automatic apb(input bit wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] m,
                     input logic err);
    int n;
    if (!wr) rq.push_back({m, d & m});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      check(32'h0, 32'h1, "apb wait");
      tally_and_finish();
    end
    check({31'h0, pslverr}, {31'h0, err}, "slverr");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Sends 4-p bytes, the last one ending the frame.
  task automatic rx_frame(input int p, input bit st, input bit keep);
    logic [31:0] e;
    e = 32'h0;
    if (st) begin
      rx_frame_start <= 1'b1;
      @(posedge pclk);
      rx_frame_start <= 1'b0;
      @(posedge pclk);
    end
    for (int k = p; k < 4; k++) begin
      seed = xs(seed);
      e[8*(3-k) +: 8] = seed[7:0];
      if (keep && k == 3) wq.push_back({32'hFFFF_FFFF >> (8*p), e});
      rx_byte <= seed[7:0];
      rx_byte_valid <= 1'b1;
      rx_frame_end <= (k == 3);
      @(posedge pclk);
      rx_byte_valid <= 1'b0;
      rx_frame_end <= 1'b0;
      @(posedge pclk);
    end
    repeat (3) @(posedge pclk);
  endtask
  // Twenty bit times, so a pattern change waiting for its byte boundary
  // has fully reached the line, then count ones among the last eight.
  task automatic idle_ones(input int n);
    repeat (16 * 20) @(posedge pclk);
    check($countones(hist), n, "idle ones");
  endtask
  // Watcher: records line bits and pulses, checks queued results.
  always @(posedge pclk) begin
    if (tx_bit_tick === 1'b1) hist <= {hist[6:0], txd};
    rxh <= {rxh[1:0], rxd};
    if (tx_fifo_clear === 1'b1) seen_clr <= 1'b1;
    if (frame_drop === 1'b1) seen_drop <= 1'b1;
    if (psel && penable && pready === 1'b1 && !pwrite) pop(rq, prdata, "rd");
    if (rx_word_valid === 1'b1) pop(wq, rx_word, "word");
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rx_byte, hist} = '0;
    {rx_byte_valid, rx_frame_start, rx_frame_end, tx_desc_check} = '0;
    {tx_desc_owned, rx_desc_check, rx_desc_owned, rx_dma_load} = '0;
    {rx_dma_step, rx_dma_base, cts_off, dcd_off, seen_clr, seen_drop} = '0;
    tx_avail = 1'b0;
    seed = 32'd31;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, HCU_OFS_CTRL, HCU_CTRL_RST, '1, 0);
    apb(1, HCU_OFS_CTRL, 32'hF100_0000, 0, 0);
    apb(0, HCU_OFS_CTRL, 32'h1100_0000, '1, 0);
    check(terminal_ready_n, 0, "dtr");
    apb(0, 8'h0C, 0, '1, 1);
    apb(1, HCU_OFS_CTRL, 0, 0, 0);
    @(posedge pclk);
    check(terminal_ready_n, 1, "dtr");
    $display("registers done");
    apb(1, HCU_OFS_CTRL, 32'h0002_0000, 0, 0);
    idle_ones(6);
    apb(1, HCU_OFS_CTRL, 0, 0, 0);
    idle_ones(8);
    cts_off <= 1'b1;
    apb(1, HCU_OFS_CTRL, 32'h0002_0030, 0, 0);
    idle_ones(8);
    dcd_off <= 1'b1;
    apb(1, HCU_OFS_CTRL, 32'h1000_0030, 0, 0);
    repeat (8) @(posedge pclk);
    check({tx_fifo_clear, rx_halt}, 2'b11, "auto modem");
    {cts_off, dcd_off} <= 2'b00;
    $display("idle and modem done");
    for (int x = 0; x < 2; x++) begin
      apb(1, HCU_OFS_CTRL, 0, 0, 0);
      seen_clr <= 1'b0;
      apb(1, HCU_OFS_CTRL, 32'h0042_0000 | (x << 21), 0, 0);
      apb(0, HCU_OFS_CTRL, 0, 32'h0040_0000, 0);
      check(seen_clr, 1, "fifo clear");
      idle_ones(x ? 8 : 6);
    end
    $display("abort done");
    for (int p = 0; p < 4; p++) begin
      apb(1, HCU_OFS_CTRL, p << HCU_B_ALIGN, 0, 0);
      rx_frame(p, 1, 1);
    end
    rx_frame(4, 1, 0);
    apb(1, HCU_OFS_CTRL, 32'h0200_0000, 0, 0);
    rx_frame(0, 0, 0);
    rx_frame(0, 1, 1);
    apb(0, HCU_OFS_CTRL, 0, 32'h0200_0000, 0);
    check(seen_drop, 1, "drop");
    $display("receive done");
    apb(1, HCU_OFS_CTRL, 32'h0C00_0000, 0, 0);
    @(posedge pclk);
    check({tx_crc_append, rx_crc_check}, 2'b00, "crc off");
    apb(1, HCU_OFS_CTRL, 0, 0, 0);
    @(posedge pclk);
    check({tx_crc_append, rx_crc_check}, 2'b11, "crc on");
    for (int i = 0; i < 4; i++) begin
      apb(1, HCU_OFS_CTRL, {16'h0, i[0], i[0], 14'h0}, 0, 0);
      tx_desc_check <= !i[1];
      rx_desc_check <= i[1];
      @(posedge pclk);
      {tx_desc_check, rx_desc_check} <= 2'b00;
      @(posedge pclk);
      check({tx_dma_stop, tx_desc_skip, rx_dma_stop, rx_desc_skip},
        i[1] ? {2'b00, i[0], !i[0]} : {i[0], !i[0], 2'b00}, "desc");
    end
    for (int i = 0; i < 2; i++) begin
      apb(1, HCU_OFS_CTRL, i << HCU_B_ADEC, 0, 0);
      seed = xs(seed);
      rx_dma_base <= seed;
      rx_dma_load <= 1'b1;
      @(posedge pclk);
      rx_dma_load <= 1'b0;
      rx_dma_step <= 1'b1;
      @(posedge pclk);
      rx_dma_step <= 1'b0;
      repeat (2) @(posedge pclk);
      check(rx_dma_addr, i ? seed - HCU_ADDR_STEP : seed + HCU_ADDR_STEP,
        "addr");
    end
    // Echo alone, then echo with loop-back: the pin follows the line.
    for (int j = 0; j < 2; j++) begin
      apb(1, HCU_OFS_CTRL, 32'h0010_0000 | (j << HCU_B_LOOP), 0, 0);
      repeat (32) begin
        @(posedge pclk);
        check(txd, rxh[2], "echo");
        if (!j) check(rx_serial, rxh[2], "rx path");
      end
    end
    // Three preamble bytes of 55, then the opening flag and frame data.
    apb(1, HCU_OFS_PRMB, 32'h0000_0355, 0, 0);
    apb(1, HCU_OFS_CTRL, 32'h0080_0000, 0, 0);
    tx_avail <= 1'b1;
    idle_ones(4);
    repeat (16 * 24) @(posedge pclk);
    check(tx_frame_go, 1, "frame go");
    $display("dma done");
    check(wq.size(), 0, "words left");
    tally_and_finish();
  end
endmodule // test_hcu_ctrl
`default_nettype wire
